// ===== rtl/bgo_pkg.sv
package bgo_pkg;

    localparam int CLK_PERIOD_NS = 20;
    localparam int CNT_W         = 10;
    localparam int LS_NUM        = 3;

    // brake blank, brake drain-source filter and supply overvoltage release filter
    localparam int T_BLK_BRAKE1_NS  = 2000;
    localparam int T_BLK_BRAKE2_NS  = 4000;
    localparam int T_FVDS_BRAKE_NS  = 1000;
    localparam int T_OV_BR_FILT_NS  = 10000;

    // overcurrent filter times, one per code of the filter field
    localparam int T_FOC0_NS = 1000;
    localparam int T_FOC1_NS = 2000;
    localparam int T_FOC2_NS = 4000;
    localparam int T_FOC3_NS = 8000;

    // least times round up to whole cycles
    function automatic logic [CNT_W-1:0] ns2cyc(input int ns);
        return CNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction

    localparam logic [CNT_W-1:0] BLK1_CYC   = ns2cyc(T_BLK_BRAKE1_NS);
    localparam logic [CNT_W-1:0] BLK2_CYC   = ns2cyc(T_BLK_BRAKE2_NS);
    localparam logic [CNT_W-1:0] FVDS_CYC   = ns2cyc(T_FVDS_BRAKE_NS);
    localparam logic [CNT_W-1:0] OVFILT_CYC = ns2cyc(T_OV_BR_FILT_NS);
    localparam logic [CNT_W-1:0] FOC0_CYC   = ns2cyc(T_FOC0_NS);
    localparam logic [CNT_W-1:0] FOC1_CYC   = ns2cyc(T_FOC1_NS);
    localparam logic [CNT_W-1:0] FOC2_CYC   = ns2cyc(T_FOC2_NS);
    localparam logic [CNT_W-1:0] FOC3_CYC   = ns2cyc(T_FOC3_NS);

    // amplifier gain values per gain code
    localparam logic [5:0] GAIN_C0 = 6'h0a;
    localparam logic [5:0] GAIN_C1 = 6'h14;
    localparam logic [5:0] GAIN_C2 = 6'h28;
    localparam logic [5:0] GAIN_C3 = 6'h3c;

    // overcurrent offset from mid-supply, in twentieths of supply
    localparam logic [2:0] UNI_TH0 = 3'h0;
    localparam logic [2:0] UNI_TH1 = 3'h2;
    localparam logic [2:0] UNI_TH2 = 3'h4;
    localparam logic [2:0] UNI_TH3 = 3'h6;
    localparam logic [2:0] BI_TH0  = 3'h2;
    localparam logic [2:0] BI_TH1  = 3'h4;
    localparam logic [2:0] BI_TH2  = 3'h5;
    localparam logic [2:0] BI_TH3  = 3'h6;

    // pin synchroniser lane positions
    localparam int SY_PWM1   = 0;
    localparam int SY_MOV    = 1;
    localparam int SY_IOV    = 2;
    localparam int SY_MHYS   = 3;
    localparam int SY_IHYS   = 4;
    localparam int SY_OC     = 5;
    localparam int SY_VDS    = 6;
    localparam int SY_W      = SY_VDS + LS_NUM;

    typedef enum logic [3:0] {
        BGO_IDLE    = 4'h1,
        BGO_BLANK   = 4'h2,
        BGO_MONITOR = 4'h4,
        BGO_FAULT   = 4'h8
    } bgo_state_e;

endpackage

// ===== rtl/bgo_filter.sv
`timescale 1ns/10ps
`default_nettype none

// output rises once the input has stayed high for thr_cyc consecutive cycles
module bgo_filter #(
    parameter int CW = 10
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          sig_in,
    input  wire logic [CW-1:0] thr_cyc,
    output logic               sig_q
);

    logic [CW-1:0] cnt_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (!sig_in) begin
            cnt_r <= '0;
        end else if (cnt_r < thr_cyc) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sig_q <= 1'b0;
        end else begin
            sig_q <= sig_in && (cnt_r + 1'b1 >= thr_cyc);
        end
    end

endmodule

`default_nettype wire

// ===== rtl/bgo_guard.sv
`timescale 1ns/10ps
`default_nettype none

module bgo_guard
    import bgo_pkg::*;
#(
    parameter int LS_N = LS_NUM
) (
    input  wire logic            sys_clk,
    input  wire logic            rst,
    input  wire logic            hard_brake_mode,
    input  wire logic            pwm1_pin,
    input  wire logic            parking_brake_enable,
    input  wire logic            low_power_mode,
    input  wire logic            supply_overvoltage_brake_enable,
    input  wire logic            main_supply_ov_pin,
    input  wire logic            internal_supply_ov_pin,
    input  wire logic            main_supply_above_hys_pin,
    input  wire logic            internal_supply_above_hys_pin,
    input  wire logic            brake_vds_threshold_select,
    input  wire logic            brake_blank_select,
    input  wire logic [LS_N-1:0] hard_brake_lowside_disable,
    input  wire logic [LS_N-1:0] lowside_vds_over_pin,
    input  wire logic [LS_N-1:0] lowside_fault_clear,
    input  wire logic            main_ov_flag_clear,
    input  wire logic            internal_ov_flag_clear,
    input  wire logic            charge_pump_enable,
    input  wire logic            sense_direction_select,
    input  wire logic [1:0]      sense_gain_field,
    input  wire logic [1:0]      overcurrent_threshold_field,
    input  wire logic            overcurrent_shutdown_enable,
    input  wire logic [1:0]      overcurrent_filter_field,
    input  wire logic            overcurrent_comp_pin,
    input  wire logic            overcurrent_flag_clear,
    output logic [LS_N-1:0]      lowside_on_r,
    output logic                 charge_pump_on_r,
    output logic                 all_fets_off_r,
    output logic                 vds_monitor_on_r,
    output logic                 vds_threshold_sel_r,
    output logic [LS_N-1:0]      lowside_brake_vds_fault_r,
    output logic                 main_supply_ov_brake_flag_r,
    output logic                 internal_supply_ov_brake_flag_r,
    output logic                 amp_enable_r,
    output logic                 amp_bidir_r,
    output logic [5:0]           amp_gain_r,
    output logic [2:0]           oc_offset_twentieths_r,
    output logic                 overcurrent_flag_r
);

    localparam int SW = SY_VDS + LS_N;

    logic [SW-1:0]    sync1_r;
    logic [SW-1:0]    sync2_r;
    logic [SW-1:0]    pin_raw;
    bgo_state_e       st_r;
    bgo_state_e       st_nxt;
    logic [CNT_W-1:0] blank_cnt_r;
    logic             ov_brake_r;
    logic             ov_release_q;
    logic [LS_N-1:0]  vds_q;
    logic [LS_N-1:0]  fault_set;
    logic             fault_any;
    logic             fault_set_any;
    logic             slam_req;
    logic             park_req;
    logic             brake_req;
    logic             oc_kill;
    logic             oc_q;
    logic [CNT_W-1:0] oc_thr;
    logic [LS_N-1:0]  lowside_nxt;
    logic             cp_nxt;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // pins cross into sys_clk through two flops before any use
    assign pin_raw = {lowside_vds_over_pin, overcurrent_comp_pin,
                      internal_supply_above_hys_pin, main_supply_above_hys_pin,
                      internal_supply_ov_pin, main_supply_ov_pin, pwm1_pin};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    // brake sources
    assign slam_req  = hard_brake_mode && sync2_r[SY_PWM1];
    assign park_req  = parking_brake_enable && low_power_mode;
    assign brake_req = slam_req || park_req || ov_brake_r;
    assign fault_any = |lowside_brake_vds_fault_r;
    assign fault_set_any = |fault_set;
    assign oc_kill   = overcurrent_flag_r && overcurrent_shutdown_enable;

    // supply overvoltage brake holds until both supplies fall back and stay down
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ov_brake_r <= 1'b0;
        end else if (supply_overvoltage_brake_enable
                     && (sync2_r[SY_MOV] || sync2_r[SY_IOV])) begin
            ov_brake_r <= 1'b1;
        end else if (!supply_overvoltage_brake_enable || ov_release_q) begin
            ov_brake_r <= 1'b0;
        end
    end

    bgo_filter #(
        .CW (CNT_W)
    ) u_ov_release (
        .sys_clk (sys_clk),
        .rst     (rst),
        .sig_in  (ov_brake_r && !sync2_r[SY_MHYS] && !sync2_r[SY_IHYS]),
        .thr_cyc (OVFILT_CYC),
        .sig_q   (ov_release_q)
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            main_supply_ov_brake_flag_r     <= 1'b0;
            internal_supply_ov_brake_flag_r <= 1'b0;
        end else begin
            // set wins over a clear in the same cycle
            if (supply_overvoltage_brake_enable && sync2_r[SY_MOV]) begin
                main_supply_ov_brake_flag_r <= 1'b1;
            end else if (main_ov_flag_clear) begin
                main_supply_ov_brake_flag_r <= 1'b0;
            end
            if (supply_overvoltage_brake_enable && sync2_r[SY_IOV]) begin
                internal_supply_ov_brake_flag_r <= 1'b1;
            end else if (internal_ov_flag_clear) begin
                internal_supply_ov_brake_flag_r <= 1'b0;
            end
        end
    end

    // brake sequence: blank, then monitor, then latched fault
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            BGO_IDLE: begin
                if (brake_req && !fault_any) begin
                    st_nxt = BGO_BLANK;
                end
            end
            BGO_BLANK: begin
                if (!brake_req) begin
                    st_nxt = BGO_IDLE;
                end else if (blank_cnt_r <= 10'h001) begin
                    st_nxt = BGO_MONITOR;
                end
            end
            BGO_MONITOR: begin
                if (fault_set_any) begin
                    st_nxt = BGO_FAULT;
                end else if (!brake_req) begin
                    st_nxt = BGO_IDLE;
                end
            end
            BGO_FAULT: begin
                if (!fault_any) begin
                    st_nxt = BGO_IDLE;
                end
            end
            default: begin
                st_nxt = BGO_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= BGO_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            blank_cnt_r <= '0;
        end else if (st_r == BGO_IDLE) begin
            blank_cnt_r <= brake_blank_select ? BLK2_CYC : BLK1_CYC;
        end else if (st_r == BGO_BLANK && blank_cnt_r != '0) begin
            blank_cnt_r <= blank_cnt_r - 1'b1;
        end
    end

    // vds comparators only count outside the blank interval
    genvar gi;
    generate
        for (gi = 0; gi < LS_N; gi++) begin : g_ls
            bgo_filter #(
                .CW (CNT_W)
            ) u_vds (
                .sys_clk (sys_clk),
                .rst     (rst),
                .sig_in  (sync2_r[SY_VDS+gi] && st_r == BGO_MONITOR && brake_req),
                .thr_cyc (FVDS_CYC),
                .sig_q   (vds_q[gi])
            );

            assign fault_set[gi] = vds_q[gi] && st_r == BGO_MONITOR;

            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    lowside_brake_vds_fault_r[gi] <= 1'b0;
                end else if (fault_set[gi]) begin
                    lowside_brake_vds_fault_r[gi] <= 1'b1;
                end else if (lowside_fault_clear[gi]) begin
                    lowside_brake_vds_fault_r[gi] <= 1'b0;
                end
            end

            // a disabled low-side still obeys parking and overvoltage brakes
            assign lowside_nxt[gi] = ((slam_req && !hard_brake_lowside_disable[gi])
                                      || park_req || ov_brake_r)
                                     && !fault_any && !fault_set_any && !oc_kill;
        end
    endgenerate

    // charge pump stays off while braking on the low-sides or while a fault is held
    assign cp_nxt = charge_pump_enable && !brake_req && !fault_any
                    && !fault_set_any && !oc_kill;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lowside_on_r     <= '0;
            charge_pump_on_r <= 1'b0;
            amp_enable_r     <= 1'b0;
            all_fets_off_r   <= 1'b0;
        end else begin
            lowside_on_r     <= lowside_nxt;
            charge_pump_on_r <= cp_nxt;
            amp_enable_r     <= cp_nxt;
            all_fets_off_r   <= oc_kill;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vds_monitor_on_r    <= 1'b0;
            vds_threshold_sel_r <= 1'b0;
        end else begin
            vds_monitor_on_r    <= brake_req;
            vds_threshold_sel_r <= brake_vds_threshold_select;
        end
    end

    // amplifier configuration decode
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            amp_bidir_r            <= 1'b0;
            amp_gain_r             <= GAIN_C0;
            oc_offset_twentieths_r <= UNI_TH0;
        end else begin
            amp_bidir_r <= sense_direction_select;
            unique case (sense_gain_field)
                2'h0: amp_gain_r <= GAIN_C0;
                2'h1: amp_gain_r <= GAIN_C1;
                2'h2: amp_gain_r <= GAIN_C2;
                2'h3: amp_gain_r <= GAIN_C3;
            endcase
            unique case ({sense_direction_select, overcurrent_threshold_field})
                3'h0: oc_offset_twentieths_r <= UNI_TH0;
                3'h1: oc_offset_twentieths_r <= UNI_TH1;
                3'h2: oc_offset_twentieths_r <= UNI_TH2;
                3'h3: oc_offset_twentieths_r <= UNI_TH3;
                3'h4: oc_offset_twentieths_r <= BI_TH0;
                3'h5: oc_offset_twentieths_r <= BI_TH1;
                3'h6: oc_offset_twentieths_r <= BI_TH2;
                3'h7: oc_offset_twentieths_r <= BI_TH3;
            endcase
        end
    end

    // overcurrent path; a dead amplifier cannot report
    always_comb begin
        unique case (overcurrent_filter_field)
            2'h0: oc_thr = FOC0_CYC;
            2'h1: oc_thr = FOC1_CYC;
            2'h2: oc_thr = FOC2_CYC;
            2'h3: oc_thr = FOC3_CYC;
        endcase
    end

    bgo_filter #(
        .CW (CNT_W)
    ) u_oc (
        .sys_clk (sys_clk),
        .rst     (rst),
        .sig_in  (sync2_r[SY_OC] && amp_enable_r),
        .thr_cyc (oc_thr),
        .sig_q   (oc_q)
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            overcurrent_flag_r <= 1'b0;
        end else if (oc_q) begin
            overcurrent_flag_r <= 1'b1;
        end else if (overcurrent_flag_clear) begin
            overcurrent_flag_r <= 1'b0;
        end
    end

    // the filters themselves must stay quiet, not only the fault latch
    blank_masks_fault_a: assert property (
        (st_r == BGO_BLANK) |-> (vds_q == '0) && !fault_set_any
    ) else $error("vds fault raised during brake blank");

    fault_lowside_off_a: assert property (
        fault_any |-> (lowside_on_r == '0)
    ) else $error("low-side on while brake fault held");

    fault_cp_off_a: assert property (
        fault_any |=> !charge_pump_on_r
    ) else $error("charge pump on while brake fault held");

    amp_needs_cp_a: assert property (
        !charge_pump_on_r |-> !amp_enable_r
    ) else $error("amplifier on without charge pump");

    ov_flag_sticky_a: assert property (
        main_supply_ov_brake_flag_r && !main_ov_flag_clear |=> main_supply_ov_brake_flag_r
    ) else $error("overvoltage flag dropped without clear");

    oc_shutdown_a: assert property (
        overcurrent_flag_r && overcurrent_shutdown_enable |=> all_fets_off_r && lowside_on_r == '0
    ) else $error("overcurrent shutdown not applied");

    oc_report_only_a: assert property (
        !overcurrent_shutdown_enable |=> !all_fets_off_r
    ) else $error("gates touched with shutdown disabled");

    slam_brake_on_a: assert property (
        slam_req && !hard_brake_lowside_disable[0] && !fault_any && !fault_set_any && !oc_kill
        |=> lowside_on_r[0] && !charge_pump_on_r
    ) else $error("hard brake did not turn low-side on");

    ov_brake_on_a: assert property (
        supply_overvoltage_brake_enable && sync2_r[SY_MOV] && !fault_any && !oc_kill
        ##1 (!fault_any && !fault_set_any && !oc_kill) |=> lowside_on_r == '1
    ) else $error("overvoltage brake did not turn low-sides on");

endmodule

`default_nettype wire

// ===== tb/bgo_fet_model.sv
`timescale 1ns/10ps
`default_nettype none

// far side: low-side fets with optional drain-source shorts, and two supplies
// supply level code: 0 normal, 1 inside hysteresis band, 2 above ov-brake threshold
module bgo_fet_model (
    input  wire logic       sys_clk,
    input  wire logic [2:0] lowside_on,
    input  wire logic [2:0] short_mask,
    input  wire logic [1:0] main_level,
    input  wire logic [1:0] int_level,
    output logic      [2:0] vds_over,
    output logic            main_ov,
    output logic            main_hys,
    output logic            int_ov,
    output logic            int_hys
);
    // a shorted fet shows high vds only while its gate is driven on
    always_ff @(posedge sys_clk) begin
        vds_over <= lowside_on & short_mask;
    end
    assign main_ov  = (main_level == 2'h2);
    assign main_hys = (main_level != 2'h0);
    assign int_ov   = (int_level == 2'h2);
    assign int_hys  = (int_level != 2'h0);
endmodule

`default_nettype wire

// ===== tb/test_brake_and_overcurrent_guard.sv
`timescale 1ns/10ps
`default_nettype none

module test_brake_and_overcurrent_guard;
    import bgo_pkg::*;
    logic sys_clk, rst, hard, pwm1, park, lp, ovb_en, vth, blk, cp_en, dir, oc_en, oc_cmp;
    logic mclr, iclr, occlr;
    logic [2:0] dis, fclr, short_m, vds, ls_on, fault;
    logic [1:0] gain_f, th_f, filt_f, mlev, ilev;
    logic mov, mhys, iov, ihys, cp_on, all_off, mon_on, vsel, mflag, iflag, amp_en, bidir, ocf;
    logic [5:0] gain;
    logic [2:0] ofs;
    int miscompares, comparisons;

    bgo_guard uut (
        .sys_clk(sys_clk), .rst(rst), .hard_brake_mode(hard), .pwm1_pin(pwm1),
        .parking_brake_enable(park), .low_power_mode(lp),
        .supply_overvoltage_brake_enable(ovb_en), .main_supply_ov_pin(mov),
        .internal_supply_ov_pin(iov), .main_supply_above_hys_pin(mhys),
        .internal_supply_above_hys_pin(ihys), .brake_vds_threshold_select(vth),
        .brake_blank_select(blk), .hard_brake_lowside_disable(dis),
        .lowside_vds_over_pin(vds), .lowside_fault_clear(fclr), .main_ov_flag_clear(mclr),
        .internal_ov_flag_clear(iclr), .charge_pump_enable(cp_en),
        .sense_direction_select(dir), .sense_gain_field(gain_f),
        .overcurrent_threshold_field(th_f), .overcurrent_shutdown_enable(oc_en),
        .overcurrent_filter_field(filt_f), .overcurrent_comp_pin(oc_cmp),
        .overcurrent_flag_clear(occlr), .lowside_on_r(ls_on), .charge_pump_on_r(cp_on),
        .all_fets_off_r(all_off), .vds_monitor_on_r(mon_on), .vds_threshold_sel_r(vsel),
        .lowside_brake_vds_fault_r(fault), .main_supply_ov_brake_flag_r(mflag),
        .internal_supply_ov_brake_flag_r(iflag), .amp_enable_r(amp_en),
        .amp_bidir_r(bidir), .amp_gain_r(gain), .oc_offset_twentieths_r(ofs),
        .overcurrent_flag_r(ocf)
    );

    bgo_fet_model far (
        .sys_clk(sys_clk), .lowside_on(ls_on), .short_mask(short_m), .main_level(mlev),
        .int_level(ilev), .vds_over(vds), .main_ov(mov), .main_hys(mhys), .int_ov(iov),
        .int_hys(ihys)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic t_config();
        logic [5:0] gtab [4];
        logic [2:0] otab [8];
        gtab = '{6'h0a, 6'h14, 6'h28, 6'h3c};
        otab = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h2, 3'h4, 3'h5, 3'h6};
        for (int i = 0; i < 4; i++) begin
            gain_f = 2'(i);
            cyc(3);
            chk_vec(gain, gtab[i], "gain");
        end
        for (int d = 0; d < 2; d++) begin
            for (int i = 0; i < 4; i++) begin
                dir = d[0];
                th_f = 2'(i);
                cyc(3);
                chk_bit(bidir, d[0], "direction");
                chk_vec({3'h0, ofs}, {3'h0, otab[d*4+i]}, "oc threshold");
            end
        end
        vth = 1'b1;
        cyc(3);
        chk_bit(vsel, 1'b1, "vds threshold select");
    endtask

    task automatic pulse_fclr(input logic [2:0] m);
        fclr = m;
        cyc(1);
        fclr = 3'h0;
        cyc(4);
    endtask

    task automatic t_hard_brake();
        short_m = 3'h1;
        hard = 1'b1;
        pwm1 = 1'b1;
        cyc(4);
        chk_vec({3'h0, ls_on}, 6'h07, "hard brake on");
        chk_bit(cp_on, 1'b0, "pump off braking");
        chk_bit(mon_on, 1'b1, "monitor on");
        cyc(90);
        chk_vec({3'h0, fault}, 6'h00, "fault in blank");
        cyc(80);
        chk_vec({3'h0, fault}, 6'h01, "fault latched");
        chk_vec({3'h0, ls_on}, 6'h00, "low-sides killed");
        short_m = 3'h0;
        hard = 1'b0;
        pwm1 = 1'b0;
        cyc(10);
        chk_vec({3'h0, fault}, 6'h01, "fault sticky");
        chk_bit(cp_on, 1'b0, "pump held off");
        dis = 3'h1;
        hard = 1'b1;
        pwm1 = 1'b1;
        cyc(10);
        chk_vec({3'h0, ls_on}, 6'h00, "held off until clear");
        pulse_fclr(3'h1);
        chk_vec({3'h0, fault}, 6'h00, "fault cleared");
        chk_vec({3'h0, ls_on}, 6'h06, "disabled low-side stays off");
        hard = 1'b0;
        pwm1 = 1'b0;
        dis = 3'h0;
        cyc(6);
        chk_bit(mon_on, 1'b0, "monitor off after brake");
        chk_bit(cp_on, 1'b1, "pump back");
        chk_bit(amp_en, 1'b1, "amp follows pump");
    endtask

    task automatic t_long_blank();
        blk = 1'b1;
        short_m = 3'h2;
        hard = 1'b1;
        pwm1 = 1'b1;
        cyc(184);
        chk_vec({3'h0, fault}, 6'h00, "long blank masks");
        cyc(80);
        chk_vec({3'h0, fault}, 6'h02, "fault after long blank");
        hard = 1'b0;
        pwm1 = 1'b0;
        short_m = 3'h0;
        pulse_fclr(3'h2);
    endtask

    task automatic t_parking();
        park = 1'b1;
        cyc(6);
        chk_vec({3'h0, ls_on}, 6'h00, "parking needs low power");
        lp = 1'b1;
        cyc(6);
        chk_vec({3'h0, ls_on}, 6'h07, "parking brake");
        park = 1'b0;
        lp = 1'b0;
        cyc(6);
    endtask

    task automatic t_ov_brake();
        ovb_en = 1'b1;
        lp = 1'b1;
        mlev = 2'h2;
        cyc(6);
        chk_bit(mflag, 1'b1, "main ov flag");
        chk_vec({3'h0, ls_on}, 6'h07, "ov brake in low power");
        mlev = 2'h1;
        cyc(20);
        chk_vec({3'h0, ls_on}, 6'h07, "held inside hysteresis");
        mlev = 2'h0;
        cyc(450);
        chk_vec({3'h0, ls_on}, 6'h07, "release filter running");
        cyc(70);
        chk_vec({3'h0, ls_on}, 6'h00, "release after filter");
        chk_bit(mflag, 1'b1, "main flag sticky");
        ilev = 2'h2;
        cyc(6);
        chk_bit(iflag, 1'b1, "internal ov flag");
        chk_vec({3'h0, ls_on}, 6'h07, "internal ov brake");
        ilev = 2'h0;
        // clear only once the synced ov level is gone, else the set wins
        cyc(4);
        mclr = 1'b1;
        iclr = 1'b1;
        cyc(1);
        mclr = 1'b0;
        iclr = 1'b0;
        cyc(526);
        chk_vec({3'h0, ls_on}, 6'h00, "internal release");
        chk_bit(mflag | iflag, 1'b0, "ov flags cleared");
        ovb_en = 1'b0;
        lp = 1'b0;
    endtask

    task automatic t_overcurrent();
        cp_en = 1'b0;
        cyc(4);
        chk_bit(amp_en, 1'b0, "amp off with pump");
        cp_en = 1'b1;
        cyc(4);
        oc_cmp = 1'b1;
        cyc(40);
        chk_bit(ocf, 1'b0, "short filter running");
        cyc(30);
        chk_bit(ocf, 1'b1, "oc flag only");
        chk_bit(all_off, 1'b0, "no shutdown");
        oc_cmp = 1'b0;
        cyc(5);
        chk_bit(ocf, 1'b1, "oc flag sticky");
        occlr = 1'b1;
        cyc(1);
        occlr = 1'b0;
        filt_f = 2'h3;
        oc_en = 1'b1;
        oc_cmp = 1'b1;
        cyc(380);
        chk_bit(ocf, 1'b0, "long filter running");
        cyc(40);
        chk_bit(all_off, 1'b1, "oc shutdown");
        oc_cmp = 1'b0;
        cyc(5);
        chk_bit(all_off, 1'b1, "shutdown holds");
        occlr = 1'b1;
        cyc(1);
        occlr = 1'b0;
        cyc(3);
        chk_bit(all_off, 1'b0, "released by clear");
        filt_f = 2'h0;
        oc_cmp = 1'b1;
        cyc(70);
        oc_cmp = 1'b0;
        chk_bit(all_off, 1'b1, "second shutdown");
        oc_en = 1'b0;
        cyc(4);
        chk_bit(all_off, 1'b0, "released by enable");
    endtask

    initial begin
        miscompares = 0;
        comparisons = 0;
        {hard, pwm1, park, lp, ovb_en, vth, blk, dir, oc_en, oc_cmp, mclr, iclr, occlr} = '0;
        {dis, fclr, short_m, gain_f, th_f, filt_f, mlev, ilev} = '0;
        cp_en = 1'b1;
        rst = 1'b1;
        cyc(16);
        chk_vec(gain, 6'h0a, "reset gain");
        chk_vec({3'h0, fault}, 6'h00, "reset faults");
        chk_bit(vsel, 1'b0, "reset vds threshold select");
        rst = 1'b0;
        cyc(4);
        t_config();
        t_hard_brake();
        t_long_blank();
        t_parking();
        t_ov_brake();
        t_overcurrent();
        close_out();
    end

    // whole run needs about 2200 cycles
    initial begin
        #200000;
        miscompares++;
        close_out();
    end
endmodule

`default_nettype wire
